// ==== rtl/line_ctrl_pkg.sv ====
// constants shared by the line interface control register bank
// assumes a 32-bit classic wishbone slave port, one word per register
package line_ctrl_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_INTL_CONTROL_SECOND = 8'h11;
    localparam logic [7:0] IDX_INTL_CONTROL_THIRD = 8'h12;
    localparam logic [7:0] IDX_TERM_CONFIG = 8'h10;
    localparam int ADDR_SHIFT = 2;

    // reset values
    localparam logic [7:0] RST_INTL_CONTROL_SECOND = 8'h00;
    localparam logic [7:0] RST_INTL_CONTROL_THIRD = 8'h00;
    localparam logic [1:0] RST_TERM_SELECT = 2'h0;

    // second register: bit 7 unassigned, bits 6..0 writable
    localparam logic [7:0] SECOND_WRITE_MASK = 8'h7f;
    localparam int BIT_MANUAL_CALIBRATE = 6;
    localparam int BIT_AUTO_CAL_DISABLE = 5;
    localparam int BIT_CURRENT_LIMIT = 4;
    localparam int BIT_OVERLOAD_PROTECT = 3;
    localparam int BIT_BILLING_TONE_EN = 2;
    localparam int BIT_RX_OVERLOAD_FLAG = 1;
    localparam int BIT_BILLING_TONE_DET = 0;

    // third register fields
    localparam int BIT_FULL_SCALE = 7;
    localparam int BIT_TONE_HEADROOM = 6;
    localparam int BIT_FORCE_JAPAN = 5;
    localparam int BIT_VOLTAGE_LOWER = 4;
    localparam int BIT_FORCE_LOW_V = 3;
    localparam int BIT_RING_FULL_WAVE = 1;
    localparam int BIT_RING_SQUELCH = 0;
    localparam int BIT_MODE_CTRL = 2;

    // own termination config register fields
    localparam int TERM_SEL_LSB = 2;
    localparam int TERM_EFF_LSB = 4;

    // headroom advice thresholds (hex)
    localparam logic [3:0] LOOP_CURRENT_MIN = 4'h6;
    localparam logic [4:0] LINE_VOLTAGE_MIN = 5'h0c;

    // transmit level per mode, dBm, two's complement
    localparam logic signed [7:0] TX_LVL_LOW = -8'sd5;
    localparam logic signed [7:0] TX_LVL_JAPAN = -8'sd3;
    localparam logic signed [7:0] TX_LVL_STD = -8'sd1;

    // termination select encodings
    typedef enum logic [1:0] {
        TERM_LOW_VOLTAGE = 2'b00,
        TERM_JAPAN = 2'b01,
        TERM_FCC = 2'b10,
        TERM_CTR21 = 2'b11
    } term_mode_t;

    // word index from a byte address
    function automatic logic [7:0] word_index(input logic [31:0] adr);
        word_index = adr[ADDR_SHIFT +: 8];
    endfunction : word_index

endpackage : line_ctrl_pkg

// ==== rtl/term_decode.sv ====
// effective dc termination decoder
// assumes inputs come straight from registers on the same clock
`timescale 1ns/1ps
module term_decode
    import line_ctrl_pkg::*;
(
    input wire logic [1:0] termination_select_i,
    input wire logic force_japan_termination_i,
    input wire logic force_low_voltage_termination_i,
    output term_mode_t eff_mode_o,
    output logic signed [7:0] tx_level_o
);

    // force japan overrides the select field; force low voltage overrides it in fcc mode only
    always_comb
    begin
        eff_mode_o = term_mode_t'(termination_select_i);
        tx_level_o = TX_LVL_STD;
        case (term_mode_t'(termination_select_i))
            TERM_LOW_VOLTAGE: tx_level_o = TX_LVL_LOW;
            TERM_JAPAN: tx_level_o = TX_LVL_JAPAN;
            TERM_FCC: tx_level_o = TX_LVL_STD;
            TERM_CTR21: tx_level_o = TX_LVL_STD;
            default: tx_level_o = TX_LVL_STD;
        endcase
        if (force_japan_termination_i)
        begin
            // japan termination, -1 dBm still allowed
            eff_mode_o = TERM_JAPAN;
            tx_level_o = TX_LVL_STD;
        end
        else if (force_low_voltage_termination_i && (termination_select_i == TERM_FCC))
        begin
            // only honoured in fcc mode
            eff_mode_o = TERM_LOW_VOLTAGE;
            tx_level_o = TX_LVL_STD;
        end
    end

endmodule : term_decode

// ==== rtl/line_interface_control_regs.sv ====
// line interface control register bank with a classic wishbone slave
// assumes a single clock, synchronous reset, same-clock reading inputs
//
// Contract
// - second register: seven rw bits, top unassigned
// - third register: eight rw bits, reset zero
// - top bit raises full scale to +3.2 dBm
// - force japan bit selects japan termination
// - voltage lower bit drops termination voltage
// - select field: low, japan, fcc, ctr21
// - force low voltage only in fcc mode
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module line_interface_control_regs
    import line_ctrl_pkg::*;
#(
    parameter int DATA_W = 32, // wishbone data width
    parameter int ADDR_W = 32 // wishbone address width
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [DATA_W/8-1:0] sel_i,
    input wire logic [DATA_W-1:0] dat_i,
    output logic [DATA_W-1:0] dat_o,
    output logic ack_o,
    // readings from the line monitor
    input wire logic [3:0] loop_current_reading_i,
    input wire logic [4:0] line_voltage_reading_i,
    input wire logic ctr21_dialing_i,
    // second register controls
    output logic manual_calibrate_o,
    output logic auto_calibration_disable_o,
    output logic current_limit_select_o,
    output logic overload_protect_enable_o,
    output logic billing_tone_enable_o,
    output logic receive_overload_flag_o,
    output logic billing_tone_detected_o,
    // third register controls
    output logic full_scale_high_o,
    output logic tone_headroom_a_o,
    output logic termination_voltage_lower_o,
    output logic ring_detect_full_wave_o,
    output logic ring_squelch_hold_o,
    output logic mode_control_o,
    // termination outputs
    output logic [1:0] termination_mode_o,
    output logic signed [7:0] tx_level_dbm_o,
    output logic headroom_advised_o
);

    // parameter sanity
    if (DATA_W != 32)
    begin : g_bad_data_w
        $error("data width must be 32");
    end
    if (ADDR_W < 10)
    begin : g_bad_addr_w
        $error("address width too small for the register map");
    end

    // register state
    logic [7:0] second_q; // second control register
    logic [7:0] second_d;
    logic [7:0] third_q; // third control register
    logic [7:0] third_d;
    logic [1:0] term_sel_q; // termination select field
    logic [1:0] term_sel_d;
    logic ack_q; // registered acknowledge
    logic [DATA_W-1:0] rdata_q; // registered read data
    logic [DATA_W-1:0] rdata_d;
    term_mode_t eff_mode_q; // registered effective mode
    logic signed [7:0] tx_level_q; // registered transmit level
    logic headroom_q; // registered headroom advice

    // bus decode
    logic req; // new access this cycle
    logic wr_en; // write strobe on low lane
    logic [7:0] idx; // decoded word index
    logic addr_high_zero; // upper and byte-offset address bits clear
    logic hit_second;
    logic hit_third;
    logic hit_term;

    // decoder outputs
    term_mode_t eff_mode;
    logic signed [7:0] tx_level;

    // address decode
    always_comb
    begin
        idx = word_index(32'(adr_i));
        addr_high_zero = (adr_i[1:0] == 2'h0);
        if (ADDR_W > 10)
        begin
            // shift rather than slice, so a bus of exactly ten bits still elaborates
            addr_high_zero = addr_high_zero && ((32'(adr_i) >> 10) == 32'h0);
        end
        hit_second = addr_high_zero && (idx == IDX_INTL_CONTROL_SECOND);
        hit_third = addr_high_zero && (idx == IDX_INTL_CONTROL_THIRD);
        hit_term = addr_high_zero && (idx == IDX_TERM_CONFIG);
    end

    // request accepted once; ack drops the cycle after it rises
    always_comb
    begin
        req = cyc_i && stb_i && !ack_q;
        wr_en = req && we_i && sel_i[0];
    end

    // second register next value
    always_comb
    begin
        second_d = second_q;
        if (wr_en && hit_second)
        begin
            // top bit stays clear
            second_d = dat_i[7:0] & SECOND_WRITE_MASK;
        end
    end

    // third register next value
    always_comb
    begin
        third_d = third_q;
        if (wr_en && hit_third)
        begin
            third_d = dat_i[7:0];
        end
    end

    // termination select next value
    always_comb
    begin
        term_sel_d = term_sel_q;
        if (wr_en && hit_term)
        begin
            term_sel_d = dat_i[TERM_SEL_LSB +: 2];
        end
    end

    // read data mux; unmapped reads return zero
    always_comb
    begin
        rdata_d = '0;
        if (hit_second)
        begin
            rdata_d[7:0] = second_q & SECOND_WRITE_MASK;
        end
        else if (hit_third)
        begin
            rdata_d[7:0] = third_q;
        end
        else if (hit_term)
        begin
            rdata_d[TERM_SEL_LSB +: 2] = term_sel_q;
            rdata_d[TERM_EFF_LSB +: 2] = eff_mode_q;
        end
    end

    // second register storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            second_q <= RST_INTL_CONTROL_SECOND;
        end
        else
        begin
            second_q <= second_d;
        end
    end

    // third register storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            third_q <= RST_INTL_CONTROL_THIRD;
        end
        else
        begin
            third_q <= third_d;
        end
    end

    // termination select storage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            term_sel_q <= RST_TERM_SELECT;
        end
        else
        begin
            term_sel_q <= term_sel_d;
        end
    end

    // acknowledge: one cycle after request, every address answered
    // a master holding stb through ack is not taken twice, since ack_q masks req
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req;
        end
    end

    // read data captured with the request
    // clearing outside reads keeps stale data off the bus between accesses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_q <= '0;
        end
        else if (req && !we_i)
        begin
            rdata_q <= rdata_d;
        end
        else if (!req)
        begin
            rdata_q <= '0;
        end
    end

    // effective termination decode
    term_decode u_term_decode (
        .termination_select_i(term_sel_q),
        .force_japan_termination_i(third_q[BIT_FORCE_JAPAN]),
        .force_low_voltage_termination_i(third_q[BIT_FORCE_LOW_V]),
        .eff_mode_o(eff_mode),
        .tx_level_o(tx_level)
    );

    // termination outputs registered
    // one cycle of lag traded for outputs that never glitch on the analog side
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            eff_mode_q <= TERM_LOW_VOLTAGE;
            tx_level_q <= TX_LVL_LOW;
        end
        else
        begin
            eff_mode_q <= eff_mode;
            tx_level_q <= tx_level;
        end
    end

    // advice for the host when readings are low in ctr21 dialing
    // advice only: the headroom bit itself is driven by software alone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            headroom_q <= 1'b0;
        end
        else
        begin
            headroom_q <= ctr21_dialing_i && (term_sel_q == TERM_CTR21) &&
                ((loop_current_reading_i < LOOP_CURRENT_MIN) ||
                (line_voltage_reading_i < LINE_VOLTAGE_MIN));
        end
    end

    // bus outputs
    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    // second register fields
    assign manual_calibrate_o = second_q[BIT_MANUAL_CALIBRATE];
    assign auto_calibration_disable_o = second_q[BIT_AUTO_CAL_DISABLE];
    assign current_limit_select_o = second_q[BIT_CURRENT_LIMIT];
    assign overload_protect_enable_o = second_q[BIT_OVERLOAD_PROTECT];
    assign billing_tone_enable_o = second_q[BIT_BILLING_TONE_EN];
    assign receive_overload_flag_o = second_q[BIT_RX_OVERLOAD_FLAG];
    assign billing_tone_detected_o = second_q[BIT_BILLING_TONE_DET];

    // third register fields
    assign full_scale_high_o = third_q[BIT_FULL_SCALE];
    assign tone_headroom_a_o = third_q[BIT_TONE_HEADROOM];
    assign termination_voltage_lower_o = third_q[BIT_VOLTAGE_LOWER];
    assign ring_detect_full_wave_o = third_q[BIT_RING_FULL_WAVE];
    assign ring_squelch_hold_o = third_q[BIT_RING_SQUELCH];
    assign mode_control_o = third_q[BIT_MODE_CTRL];

    // termination outputs
    assign termination_mode_o = eff_mode_q;
    assign tx_level_dbm_o = tx_level_q;
    assign headroom_advised_o = headroom_q;

endmodule : line_interface_control_regs

// ==== verification/line_monitor_model.sv ====
// line monitor stand-in feeding readings to the bank
// assumes readings move only on the bank clock
`timescale 1ns/1ps
module line_monitor_model (
    input wire logic clk_i,
    input wire logic [1:0] preset_i,
    output logic [3:0] loop_current_o,
    output logic [4:0] line_voltage_o,
    output logic dialing_o
);
    // preset table: idle, low current, at thresholds, low voltage
    always_ff @(posedge clk_i)
    begin
        case (preset_i)
            2'h1: {dialing_o, loop_current_o, line_voltage_o} <= {1'b1, 4'h5, 5'h14};
            2'h2: {dialing_o, loop_current_o, line_voltage_o} <= {1'b1, 4'h6, 5'h0c};
            2'h3: {dialing_o, loop_current_o, line_voltage_o} <= {1'b1, 4'h9, 5'h0b};
            default: {dialing_o, loop_current_o, line_voltage_o} <= {1'b0, 4'h6, 5'h0c};
        endcase
    end
endmodule : line_monitor_model

// ==== verification/line_ctrl_assertions.sv ====
// timing and field checks on the bank ports
// assumes bound to the bank top module
`timescale 1ns/1ps
module line_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic manual_calibrate_o,
    input wire logic billing_tone_detected_o,
    input wire logic full_scale_high_o,
    input wire logic termination_voltage_lower_o,
    input wire logic [1:0] termination_mode_o,
    input wire logic signed [7:0] tx_level_dbm_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // request taken at this edge
    wire take = cyc_i && stb_i && !ack_o;
    // byte-enabled writes to the second and third registers
    wire wr_sec = take && we_i && sel_i[0] && adr_i == 32'h44;
    wire wr_thr = take && we_i && sel_i[0] && adr_i == 32'h48;
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> ack_o) else $error("no ack after request");
    a_ack_cause: assert property (!take |=> !ack_o) else $error("ack without request");
    a_dat_quiet: assert property (!(ack_o && !we_i) |-> dat_o == 32'h0) else $error("read data outside ack");
    a_second_top: assert property (ack_o && !we_i && adr_i == 32'h44 |-> dat_o[31:7] == 25'h0)
        else $error("unassigned bit reads set");
    a_second_write: assert property (wr_sec |=> manual_calibrate_o == $past(dat_i[6])
        && billing_tone_detected_o == $past(dat_i[0])) else $error("second register bits wrong");
    a_full_scale: assert property (wr_thr |=> full_scale_high_o == $past(dat_i[7])) else $error("full scale bit");
    a_volt_lower: assert property (wr_thr |=> termination_voltage_lower_o == $past(dat_i[4]))
        else $error("voltage lower bit");
    a_tx_upper: assert property (termination_mode_o[1] |-> tx_level_dbm_o == -8'sd1) else $error("tx level");
    // main scenarios
    c_write: cover property (wr_thr);
    c_read: cover property (take && !we_i);
    c_ctr21: cover property (termination_mode_o == 2'b11);
endmodule : line_ctrl_checker

bind line_interface_control_regs line_ctrl_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .manual_calibrate_o, .billing_tone_detected_o, .full_scale_high_o,
    .termination_voltage_lower_o, .termination_mode_o, .tx_level_dbm_o);

// ==== verification/line_interface_control_regs_bench.sv ====
// directed bench for the line control register bank
// assumes the line monitor model drives the readings
`timescale 1ns/1ps
module line_interface_control_regs_bench;
    import line_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, rd;
    logic [3:0] sel_i = 4'h0, loop_current_reading_i;
    logic [4:0] line_voltage_reading_i;
    logic [1:0] preset = 2'h0, termination_mode_o;
    logic ack_o, ctr21_dialing_i, manual_calibrate_o, auto_calibration_disable_o, current_limit_select_o,
        overload_protect_enable_o, billing_tone_enable_o, receive_overload_flag_o, billing_tone_detected_o,
        full_scale_high_o, tone_headroom_a_o, termination_voltage_lower_o, ring_detect_full_wave_o,
        ring_squelch_hold_o, mode_control_o, headroom_advised_o;
    logic signed [7:0] tx_level_dbm_o;
    logic signed [7:0] tx_tab [4] = '{TX_LVL_LOW, TX_LVL_JAPAN, TX_LVL_STD, TX_LVL_STD};
    int bad_count = 0;
    int num_checks = 0;

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    line_interface_control_regs dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .loop_current_reading_i, .line_voltage_reading_i, .ctr21_dialing_i, .manual_calibrate_o,
        .auto_calibration_disable_o, .current_limit_select_o, .overload_protect_enable_o, .billing_tone_enable_o,
        .receive_overload_flag_o, .billing_tone_detected_o, .full_scale_high_o, .tone_headroom_a_o,
        .termination_voltage_lower_o, .ring_detect_full_wave_o, .ring_squelch_hold_o, .mode_control_o,
        .termination_mode_o, .tx_level_dbm_o, .headroom_advised_o);
    line_monitor_model mon_u (.clk_i, .preset_i(preset), .loop_current_o(loop_current_reading_i),
        .line_voltage_o(line_voltage_reading_i), .dialing_o(ctr21_dialing_i));

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // one classic cycle, entered just after an edge
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        sel_i <= s;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        check(n < 20, 1);
    endtask : wb

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00, 4'h1);
        check(rd, exp);
    endtask : rdchk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // watchdog
    initial
    begin
        #20000;
        bad_count++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        check(tx_level_dbm_o, TX_LVL_LOW);
        rdchk(32'h44, 32'h0);
        rdchk(32'h48, 32'h0);
        wb(1'b1, 32'h44, 8'hff, 4'h1);
        rdchk(32'h44, 32'h7f);
        check(manual_calibrate_o, 1);
        check({manual_calibrate_o, auto_calibration_disable_o, current_limit_select_o, overload_protect_enable_o,
            billing_tone_enable_o, receive_overload_flag_o, billing_tone_detected_o}, 7'h7f);
        wb(1'b1, 32'h44, 8'h00, 4'h0);
        wb(1'b1, 32'h4c, 8'hff, 4'h1);
        rdchk(32'h4c, 32'h0);
        rdchk(32'h44, 32'h7f);
        wb(1'b1, 32'h48, 8'ha5, 4'h1);
        rdchk(32'h48, 32'ha5);
        check({full_scale_high_o, termination_voltage_lower_o}, 2'b10);
        check({tone_headroom_a_o, mode_control_o, ring_detect_full_wave_o, ring_squelch_hold_o}, 4'b0101);
        wb(1'b1, 32'h48, 8'h5a, 4'h1);
        rdchk(32'h48, 32'h5a);
        check({full_scale_high_o, termination_voltage_lower_o}, 2'b01);
        check({tone_headroom_a_o, mode_control_o, ring_detect_full_wave_o, ring_squelch_hold_o}, 4'b1010);
        wb(1'b1, 32'h48, 8'h00, 4'h1);
        for (int s = 0; s < 4; s++)
        begin
            wb(1'b1, 32'h40, 8'(s << 2), 4'h1);
            check({termination_mode_o, tx_level_dbm_o}, {s[1:0], tx_tab[s]});
        end
        wb(1'b1, 32'h48, 8'h08, 4'h1);
        check(termination_mode_o, TERM_CTR21);
        wb(1'b1, 32'h40, 8'h08, 4'h1);
        check({termination_mode_o, tx_level_dbm_o}, {TERM_LOW_VOLTAGE, TX_LVL_STD});
        rdchk(32'h40, 32'h08);
        wb(1'b1, 32'h48, 8'h28, 4'h1);
        check({termination_mode_o, tx_level_dbm_o}, {TERM_JAPAN, TX_LVL_STD});
        rdchk(32'h40, 32'h18);
        wb(1'b1, 32'h40, 8'h0c, 4'h1);
        for (int p = 0; p < 4; p++)
        begin
            preset <= p[1:0];
            repeat (3) @(posedge clk_i);
            check(headroom_advised_o, p[0]);
        end
        wb(1'b1, 32'h48, 8'h40, 4'h1);
        check(tone_headroom_a_o, 1);
        // mid-run reset must clear every field again
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(32'h48, 32'h0);
        rdchk(32'h44, 32'h0);
        rdchk(32'h40, 32'h0);
        check({manual_calibrate_o, auto_calibration_disable_o, current_limit_select_o, overload_protect_enable_o,
            billing_tone_enable_o, receive_overload_flag_o, billing_tone_detected_o}, 7'h00);
        check({tone_headroom_a_o, termination_mode_o, tx_level_dbm_o}, {1'b0, TERM_LOW_VOLTAGE, TX_LVL_LOW});
        print_verdict();
    end
endmodule : line_interface_control_regs_bench
